// ===== core/reset_combiner_defs.svh
`ifndef RESET_COMBINER_DEFS_SVH
`define RESET_COMBINER_DEFS_SVH

// register byte offsets (low address byte only is decoded)
`define ADDR_CAUSE 8'h00
`define ADDR_OSC 8'h04
`define ADDR_LIVE 8'h08

// reset cause register field positions
`define CAUSE_BOR 0
`define CAUSE_POR 1
`define CAUSE_SOFTWARE 2
`define CAUSE_WATCHDOG 3
`define CAUSE_EXT_CLEAR 4
`define CAUSE_CONFIG_MISMATCH 5
`define CAUSE_ILLEGAL 6
`define CAUSE_TRAP 7
`define CAUSE_WIDTH 8

// power-on value of the cause register: power-on and brown-out set
`define CAUSE_RESET 8'h03

// new oscillator field inside the oscillator control register
`define NEW_OSC_FIELD_LSB 8
`define NEW_OSC_FIELD_MSB 10
`define NEW_OSC_FIELD_RESET 3'h0

// cycles the system reset is held after the last source drops
`define RELEASE_HOLD 2'h2

// live status register: sources in [8:0], system reset in bit 9
`define LIVE_SYSTEM_RESET_OUT 9

`endif

// ===== core/reset_combiner_pkg.sv
package reset_combiner_pkg;

   // every reset source except power-on, which is the rst pin itself
   typedef struct packed {
      logic illegalOpcode;
      logic uninitRegister;
      logic securityViolation;
      logic trapConflict;
      logic configMismatch;
      logic watchdogTimeout;
      logic softwareReset;
      logic externalClear;
      logic brownOut;
   } reset_sources_t;

   // ahb-lite request side as seen by this slave
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } ahb_req_t;

   // data phase tracking of the bus slave
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_WRITE,
      PH_READ_WAIT,
      PH_READ_DONE
   } bus_phase_t;

endpackage

// ===== core/reset_release_sync.sv
`timescale 1ns/100ps
`include "reset_combiner_defs.svh"

module reset_release_sync
   import reset_combiner_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic anySource,
   output logic systemResetOut
);

   logic [1:0] holdCount; // cycles of hold left after sources drop

   // reset asserts on the next edge after any source, and only
   // falls on an edge once the hold count has run out
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         systemResetOut <= 1'b1;
         holdCount <= `RELEASE_HOLD;
      end else begin
         systemResetOut <= anySource | (holdCount != 2'h0); // R1 R10
         if (anySource) begin
            holdCount <= `RELEASE_HOLD;
         end else if (holdCount != 2'h0) begin
            holdCount <= holdCount - 2'h1;
         end
      end
   end

   // release only after a full quiet hold
   release_sync_a: assert property (@(posedge clk) disable iff (rst) // R10
      $fell(systemResetOut) |-> !$past(anySource) && !$past(anySource, 2) && !$past(anySource, 3))
      else $error("system reset released without a quiet hold");

   cover_release_c: cover property (@(posedge clk) disable iff (rst) $fell(systemResetOut));

endmodule // reset_release_sync

// ===== core/reset_source_combiner_status.sv
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "reset_combiner_defs.svh"
// Summary of operation
// R1: system reset is OR of all sources
// R2: eight sources, illegal covers three conditions
// R3: reset forces some registers, cause flags persist
// R4: each reset kind sets its own flag
// R5: power-on clears flags, sets power-on, brown-out
// R6: software write stores any flag value
// R7: writing flags never causes a reset
// R8: software should clear flags after reading
// R9: every reset loads oscillator selection into field
// R10: reset released synchronously to the clock

module reset_source_combiner_status
   import reset_combiner_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire reset_sources_t sources,
   input wire logic [2:0] initialOscSelect,
   input wire ahb_req_t ahb,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic systemResetOut,
   output logic [2:0] newOscField,
   output logic [`CAUSE_WIDTH-1:0] causeFlags
);

   // cause vector raised by the live sources
   function automatic logic [`CAUSE_WIDTH-1:0] causeSet(input reset_sources_t s);
      logic [`CAUSE_WIDTH-1:0] v;
      v = '0;
      v[`CAUSE_BOR] = s.brownOut;
      v[`CAUSE_SOFTWARE] = s.softwareReset;
      v[`CAUSE_WATCHDOG] = s.watchdogTimeout;
      v[`CAUSE_EXT_CLEAR] = s.externalClear;
      v[`CAUSE_CONFIG_MISMATCH] = s.configMismatch;
      v[`CAUSE_TRAP] = s.trapConflict;
      v[`CAUSE_ILLEGAL] = s.illegalOpcode | s.uninitRegister | s.securityViolation;
      return v;
   endfunction

   bus_phase_t phase; // data phase in progress
   logic [7:0] phaseAddr; // low address byte of that data phase
   logic oscLoadPending; // first edge after power-on still to load
   logic [`CAUSE_WIDTH-1:0] setVec; // flags to raise this cycle
   logic anySource; // at least one source active
   logic accept; // address phase taken this edge
   logic writeCause; // data phase writes the cause register
   logic writeOsc; // data phase writes the oscillator register
   logic loadOsc; // a reset is loading the oscillator field
   logic [31:0] readValue; // register addressed by the read
   logic [`CAUSE_WIDTH-1:0] next_cause;
   logic [2:0] next_new_osc_field;
   bus_phase_t next_phase;

   // combine and decode
   assign setVec = causeSet(sources); // R2 R4
   assign anySource = |sources; // R1 R2
   assign accept = ahb.hsel & ahb.htrans[1] & ahb.hready;
   assign writeCause = (phase == PH_WRITE) && (phaseAddr == `ADDR_CAUSE);
   assign writeOsc = (phase == PH_WRITE) && (phaseAddr == `ADDR_OSC);
   assign loadOsc = oscLoadPending | systemResetOut; // R9
   assign hreadyout = (phase != PH_READ_WAIT); // one wait state on reads only
   assign hresp = 1'b0; // always okay, unmapped reads return zero

   // a source set wins over a software write in the same cycle
   assign next_cause = (writeCause ? ahb.hwdata[`CAUSE_WIDTH-1:0] : causeFlags) | setVec; // R4 R6
   // a reset overrides any pending software clock request
   assign next_new_osc_field = loadOsc ? initialOscSelect : // R9 R3
      (writeOsc ? ahb.hwdata[`NEW_OSC_FIELD_MSB:`NEW_OSC_FIELD_LSB] : newOscField);

   // read mux; reserved bits read zero
   assign readValue = (phaseAddr == `ADDR_CAUSE) ? {24'h00_0000, causeFlags} :
      (phaseAddr == `ADDR_OSC) ? {21'h00_0000, newOscField, 8'h00} :
      (phaseAddr == `ADDR_LIVE) ? {22'h00_0000, systemResetOut, sources} : 32'h0000_0000;

   // next bus phase
   always_comb begin
      case (phase)
         PH_READ_WAIT: next_phase = PH_READ_DONE;
         default: begin
            if (accept) begin
               next_phase = ahb.hwrite ? PH_WRITE : PH_READ_WAIT;
            end else begin
               next_phase = PH_IDLE;
            end
         end
      endcase
   end

   // bus slave state; address latched in the address phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase <= PH_IDLE;
         phaseAddr <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         phase <= next_phase;
         if (accept) begin
            phaseAddr <= ahb.haddr[7:0];
         end
         if (phase == PH_READ_WAIT) begin
            hrdata <= readValue; // wait state avoids racing a prior write
         end
      end
   end

   // cause flags: only power-on and software writes clear them, system resets do not
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         causeFlags <= `CAUSE_RESET; // R5
      end else begin
         causeFlags <= next_cause; // R3 R7
      end
   end

   // oscillator field: constant under rst, config loaded at first edge after
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oscLoadPending <= 1'b1;
         newOscField <= `NEW_OSC_FIELD_RESET;
      end else begin
         oscLoadPending <= 1'b0;
         newOscField <= next_new_osc_field; // R9
      end
   end

   // synchronous release of the combined reset
   reset_release_sync releaseSync (
      .clk(clk),
      .rst(rst),
      .anySource(anySource),
      .systemResetOut(systemResetOut)
   );

   // helper: marks the first edge after power-on release
   logic firstEdge;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         firstEdge <= 1'b1;
      end else begin
         firstEdge <= 1'b0;
      end
   end

   system_reset_out_or_a: assert property (@(posedge clk) disable iff (rst) anySource |=> systemResetOut) // R1
      else $error("source active without system reset");

   illegal_flag_a: assert property (@(posedge clk) disable iff (rst) // R2
      (sources.illegalOpcode | sources.uninitRegister | sources.securityViolation) |=> causeFlags[`CAUSE_ILLEGAL])
      else $error("illegal condition not recorded");

   flags_persist_a: assert property (@(posedge clk) disable iff (rst) // R3
      systemResetOut && !writeCause && !anySource |=> causeFlags == $past(causeFlags))
      else $error("system reset disturbed cause flags");

   cause_set_a: assert property (@(posedge clk) disable iff (rst) // R4
      sources.watchdogTimeout ##0 writeCause |=> causeFlags[`CAUSE_WATCHDOG])
      else $error("watchdog cause lost to software write");

   por_flags_a: assert property (@(posedge clk) disable iff (rst) // R5
      firstEdge |-> causeFlags == `CAUSE_RESET)
      else $error("power-on cause value wrong");

   sw_store_a: assert property (@(posedge clk) disable iff (rst) // R6
      writeCause && !anySource |=> causeFlags == $past(ahb.hwdata[`CAUSE_WIDTH-1:0]))
      else $error("software cause write not stored");

   sw_no_reset_a: assert property (@(posedge clk) disable iff (rst) // R7
      (!anySource)[*4] |=> !systemResetOut)
      else $error("system reset without an active source");

   osc_load_a: assert property (@(posedge clk) disable iff (rst) // R9
      systemResetOut |=> newOscField == $past(initialOscSelect))
      else $error("oscillator selection not loaded on reset");

   cover_watchdog_c: cover property (@(posedge clk) disable iff (rst)
      sources.watchdogTimeout ##1 systemResetOut ##[1:8] !systemResetOut);
   cover_cause_write_c: cover property (@(posedge clk) disable iff (rst) writeCause);
   cover_osc_read_c: cover property (@(posedge clk) disable iff (rst)
      phase == PH_READ_WAIT && phaseAddr == `ADDR_OSC);

endmodule // reset_source_combiner_status

// ===== tb/reset_source_model.sv
`timescale 1ns/100ps

module reset_source_model
   import reset_combiner_pkg::*;
(
   input wire logic clk,
   output reset_sources_t sources
);
   // an idle source requests nothing, so every line rests low
   initial begin
      sources = '0;
   end

   // one source held active for a number of edges, then released
   task automatic pulse(input int idx, input int cycles);
      @(posedge clk);
      sources[idx] <= 1'b1;
      repeat (cycles) @(posedge clk);
      sources <= '0;
   endtask
endmodule // reset_source_model

// ===== tb/test_reset_source_combiner_status.sv
`timescale 1ns/100ps
`include "reset_combiner_defs.svh"

module test_reset_source_combiner_status
   import reset_combiner_pkg::*;
;
   logic clk;
   logic rst;
   ahb_req_t busReq; // master side, hready filled in below
   ahb_req_t ahbIn;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic systemResetOut;
   logic [2:0] newOscField;
   logic [7:0] causeFlags;
   reset_sources_t sources;
   logic [31:0] rd;
   int failCount = 0;
   int checksDone = 0;
   // cause flag bit hit by each source, lsb source first
   int causeBit[9] = '{0, 4, 2, 3, 5, 7, 6, 6, 6};

   // single slave: its hreadyout is the bus hready
   always_comb begin
      ahbIn = busReq;
      ahbIn.hready = hreadyout;
   end

   reset_source_model srcModel (.clk(clk), .sources(sources));

   reset_source_combiner_status dut_u (.clk(clk), .rst(rst), .sources(sources),
      .initialOscSelect(3'h5), .ahb(ahbIn), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .systemResetOut(systemResetOut), .newOscField(newOscField),
      .causeFlags(causeFlags));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         failCount++;
      end
   endtask

   // one single transfer; hready is looked at mid-cycle, where it is settled
   task automatic busXfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      logic rdy;
      int n;
      @(posedge clk);
      busReq.hsel <= 1'b1;
      busReq.haddr <= {24'h00_0000, addr};
      busReq.htrans <= 2'b10;
      busReq.hwrite <= wr;
      busReq.hsize <= 3'b010;
      for (int ph = 0; ph < 2; ph++) begin
         n = 0;
         do begin
            @(negedge clk);
            rdy = hreadyout;
            rd = hrdata;
            n++;
            @(posedge clk);
         end while (rdy !== 1'b1 && n < 20);
         chk(32'(rdy), 32'h0000_0001);
         chk(32'(hresp), 32'h0000_0000);
         busReq.htrans <= 2'b00;
         busReq.hwdata <= wdata;
      end
   endtask

   task automatic stopTest();
      $display("checks %0d mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #20000;
      failCount++;
      stopTest();
   end

   initial begin
      rst = 1'b1;
      busReq = '0;
      repeat (6) @(posedge clk);
      chk(32'(causeFlags), 32'h0000_0003);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(32'(systemResetOut), 32'h0000_0000);
      chk(32'(newOscField), 32'h0000_0005);
      busXfer(1'b0, `ADDR_CAUSE, 32'h0000_0000);
      chk(rd, 32'h0000_0003);
      // software may store any flag pattern without resetting anything
      busXfer(1'b1, `ADDR_CAUSE, 32'h0000_00ff);
      @(negedge clk);
      chk(32'(systemResetOut), 32'h0000_0000);
      busXfer(1'b0, `ADDR_CAUSE, 32'h0000_0000);
      chk(rd, 32'h0000_00ff);
      busXfer(1'b0, `ADDR_LIVE, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      busXfer(1'b0, 8'h0c, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      // every source alone: reset pulse, its own flag, oscillator reload
      for (int i = 0; i < 9; i++) begin
         busXfer(1'b1, `ADDR_CAUSE, 32'h0000_0000);
         busXfer(1'b1, `ADDR_OSC, 32'h0000_0200);
         busXfer(1'b0, `ADDR_OSC, 32'h0000_0000);
         chk(rd, 32'h0000_0200);
         srcModel.pulse(i, 1);
         @(negedge clk);
         chk(32'(systemResetOut), 32'h0000_0001);
         repeat (2) @(posedge clk);
         @(negedge clk);
         chk(32'(systemResetOut), 32'h0000_0001);
         @(posedge clk);
         @(negedge clk);
         chk(32'(systemResetOut), 32'h0000_0000);
         chk(32'(newOscField), 32'h0000_0005);
         chk(32'(causeFlags), 32'h0000_0001 << causeBit[i]);
         busXfer(1'b0, `ADDR_CAUSE, 32'h0000_0000);
         chk(rd, 32'h0000_0001 << causeBit[i]);
      end
      // a second power-on in mid-run must drop every other flag and reload the field
      busXfer(1'b1, `ADDR_CAUSE, 32'h0000_00fc);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(32'(causeFlags), 32'h0000_0003);
      chk(32'(systemResetOut), 32'h0000_0000);
      chk(32'(newOscField), 32'h0000_0005);
      stopTest();
   end
endmodule // test_reset_source_combiner_status
